// file: hw/dfp_pkg.sv
// types shared by the protection logic
// assumes nothing beyond a SystemVerilog compiler
package dfp_pkg;

    typedef enum logic [4:0] {
        DFP_ST_OFF     = 5'b00001,
        DFP_ST_BLANK   = 5'b00010,
        DFP_ST_MONITOR = 5'b00100,
        DFP_ST_DIS_A   = 5'b01000,
        DFP_ST_DIS_B   = 5'b10000
    } dfp_state_type;

endpackage

// file: hw/dfp_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes byte addressing on a 32-bit Avalon-MM slave
`ifndef DFP_REGS_SVH
`define DFP_REGS_SVH

`define DFP_ADDR_W          5
`define DFP_CTRL_OFS        5'h00
`define DFP_BLANK_OFS       5'h04
`define DFP_CFG2_OFS        5'h08
`define DFP_STAT_OFS        5'h0c
`define DFP_ERR_OFS         5'h10
`define DFP_MASK_OFS        5'h14

`define DFP_CTRL_CLAMP      0
`define DFP_CTRL_UNLOCK     1
`define DFP_CTRL_FAST_REACT 2
`define DFP_CTRL_REINIT     3

`define DFP_ERR_W           4
`define DFP_ERR_SAT         0
`define DFP_ERR_ENABLE      1
`define DFP_ERR_INTERNAL    2
`define DFP_ERR_CLASS_C     3

`define DFP_STAT_CMP        0
`define DFP_STAT_VALID      1
`define DFP_STAT_GATE       2
`define DFP_STAT_CLAMP      3
`define DFP_STAT_STATE_LSB  8

`define DFP_BLANK_RST       8'h10
`define DFP_THR_RST         3'h0
`define DFP_MASK_RST        4'hf

`define DFP_CLK_PERIOD_NS   8
`define DFP_BLANK_STEP_NS   100
`define DFP_BLANK_STEP_CYC \
    ((`DFP_BLANK_STEP_NS + `DFP_CLK_PERIOD_NS - 1) / `DFP_CLK_PERIOD_NS)

`endif

// file: hw/dfp_sync.sv
// three-stage input synchroniser with agreement filter
// assumes an asynchronous level on din, one clock clk
module dfp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_reg <= RST_VAL;
        end else if (s2_reg == s3_reg) begin
            out_reg <= s2_reg;
        end
    end

    assign dout = out_reg;

endmodule

// file: hw/dfp_top.sv
// desaturation monitor and fault reaction logic with register slave
// assumes one 125 MHz clock, sense comparator and enable from pins
//
// Summary of operation
// - evaluate sense only while switch commanded on
// - trip: safe turn-off, error flag, notify
// - comparator result readable in status
// - clamp sense during blanking, then compare
// - software programs blanking and threshold
// - class A disables until fast reactivation
// - class B disables until full reinitialization
// - class C only notifies, output unchanged
// - enable validity loss is class A
// - internal supervision failure is class B
// - monitor inactive while output stage off
// - clamp enable adds clamping while off
// - blanking and threshold from own fields
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`include "dfp_regs.svh"
module dfp_top #(
    parameter int BLANK_W = 8,
    parameter int THR_W   = 3
) (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic [`DFP_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   pwm_on_cmd,
    input  wire logic                   saturation_sense_pin,
    input  wire logic                   external_enable_input,
    input  wire logic                   internal_fault,
    input  wire logic                   class_c_event,
    output logic                        gate_on,
    output logic                        sense_clamp,
    output logic [THR_W-1:0]            saturation_threshold_select,
    output logic                        safe_turnoff,
    output logic                        regular_turnoff,
    output logic                        fault_notify_class_a_n,
    output logic                        fault_notify_class_b_n,
    output logic                        irq
);

    localparam int STEP_CYC = `DFP_BLANK_STEP_CYC;
    localparam int STEP_W   = $clog2(STEP_CYC + 1);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);

    generate
        if (BLANK_W < 1 || BLANK_W > 8 || THR_W < 1 || THR_W > 8) begin
            $error("dfp_top: BLANK_W and THR_W must be 1 to 8");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // declarations

    dfp_pkg::dfp_state_type state_reg;
    dfp_pkg::dfp_state_type state_next;

    logic                    ack_reg;
    logic [31:0]             rdata_reg;
    logic                    wr_fire;
    logic                    rd_take;
    logic                    wr_lane0;
    logic                    clamp_en_reg;
    logic                    unlock_reg;
    logic [BLANK_W-1:0]      saturation_blanking_time;
    logic [THR_W-1:0]        thr_reg;
    logic [`DFP_ERR_W-1:0]   err_reg;
    logic [`DFP_ERR_W-1:0]   err_set;
    logic [`DFP_ERR_W-1:0]   err_clr;
    logic [`DFP_ERR_W-1:0]   mask_reg;
    logic                    fast_react;
    logic                    reinit;
    logic                    cmp_sync;
    logic                    valid_sync;
    logic                    valid_prev_reg;
    logic                    enable_loss;
    logic                    sat_trip;
    logic [BLANK_W-1:0]      blank_left_reg;
    logic [STEP_W-1:0]       step_reg;
    logic                    blank_done;
    logic                    safe_reg;
    logic                    regular_reg;
    logic [31:0]             stat_word;

    ////////////////////////////////////////////////////////////////////////
    // pin inputs

    dfp_sync #(.RST_VAL(1'b0)) u_sync_cmp (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (saturation_sense_pin),
        .dout    (cmp_sync)
    );

    dfp_sync #(.RST_VAL(1'b0)) u_sync_en (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (external_enable_input),
        .dout    (valid_sync)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valid_prev_reg <= 1'b0;
        end else begin
            valid_prev_reg <= valid_sync;
        end
    end

    assign enable_loss = valid_prev_reg & ~valid_sync;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then the access completes

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_fire  = avs_write & ack_reg;
    assign rd_take  = avs_read & ~ack_reg;
    assign wr_lane0 = wr_fire & avs_byteenable[0];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`DFP_STAT_CMP]   = cmp_sync;
        stat_word[`DFP_STAT_VALID] = valid_sync;
        stat_word[`DFP_STAT_GATE]  = gate_on;
        stat_word[`DFP_STAT_CLAMP] = sense_clamp;
        stat_word[`DFP_STAT_STATE_LSB +: 5] = state_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            if (avs_address == `DFP_CTRL_OFS) begin
                rdata_reg <= {30'h0, unlock_reg, clamp_en_reg};
            end else if (avs_address == `DFP_BLANK_OFS) begin
                rdata_reg <= 32'(saturation_blanking_time);
            end else if (avs_address == `DFP_CFG2_OFS) begin
                rdata_reg <= 32'(thr_reg);
            end else if (avs_address == `DFP_STAT_OFS) begin
                rdata_reg <= stat_word;
            end else if (avs_address == `DFP_ERR_OFS) begin
                rdata_reg <= 32'(err_reg);
            end else if (avs_address == `DFP_MASK_OFS) begin
                rdata_reg <= 32'(mask_reg);
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    assign avs_readdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    assign fast_react = wr_lane0 && avs_address == `DFP_CTRL_OFS
                        && avs_writedata[`DFP_CTRL_FAST_REACT];
    assign reinit     = wr_lane0 && avs_address == `DFP_CTRL_OFS
                        && avs_writedata[`DFP_CTRL_REINIT];

    always_ff @(posedge clk) begin
        if (sys_rst || reinit) begin
            clamp_en_reg <= 1'b0;
            unlock_reg   <= 1'b0;
        end else if (wr_lane0 && avs_address == `DFP_CTRL_OFS) begin
            clamp_en_reg <= avs_writedata[`DFP_CTRL_CLAMP];
            unlock_reg   <= avs_writedata[`DFP_CTRL_UNLOCK];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || reinit) begin
            saturation_blanking_time <= BLANK_W'(`DFP_BLANK_RST);
        end else if (wr_lane0 && avs_address == `DFP_BLANK_OFS) begin
            saturation_blanking_time <= avs_writedata[BLANK_W-1:0];
        end
    end

    // threshold only writable while unlocked
    always_ff @(posedge clk) begin
        if (sys_rst || reinit) begin
            thr_reg <= THR_W'(`DFP_THR_RST);
        end else if (wr_lane0 && avs_address == `DFP_CFG2_OFS
                     && unlock_reg) begin
            thr_reg <= avs_writedata[THR_W-1:0];
        end
    end

    assign saturation_threshold_select = thr_reg;

    always_ff @(posedge clk) begin
        if (sys_rst || reinit) begin
            mask_reg <= `DFP_MASK_RST;
        end else if (wr_lane0 && avs_address == `DFP_MASK_OFS) begin
            mask_reg <= avs_writedata[`DFP_ERR_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky error flags, set wins over write-one clear

    always_comb begin
        err_set = '0;
        err_set[`DFP_ERR_SAT]      = sat_trip;
        err_set[`DFP_ERR_ENABLE]   = enable_loss;
        err_set[`DFP_ERR_INTERNAL] = internal_fault;
        err_set[`DFP_ERR_CLASS_C]  = class_c_event;
    end

    assign err_clr = (wr_lane0 && avs_address == `DFP_ERR_OFS)
                     ? avs_writedata[`DFP_ERR_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (sys_rst || reinit) begin
            err_reg <= '0;
        end else begin
            err_reg <= (err_reg & ~err_clr) | err_set;
        end
    end

    assign irq = |(err_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // blanking timer

    assign blank_done = (blank_left_reg == '0);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            blank_left_reg <= '0;
            step_reg       <= '0;
        end else if (state_reg == dfp_pkg::DFP_ST_OFF) begin
            blank_left_reg <= saturation_blanking_time;
            step_reg       <= STEP_LAST;
        end else if (state_reg == dfp_pkg::DFP_ST_BLANK && !blank_done) begin
            if (step_reg == '0) begin
                step_reg       <= STEP_LAST;
                blank_left_reg <= blank_left_reg - 1'b1;
            end else begin
                step_reg <= step_reg - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection state machine

    // comparator looked at only after blanking and while on
    assign sat_trip = (state_reg == dfp_pkg::DFP_ST_MONITOR)
                      && pwm_on_cmd && cmp_sync;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dfp_pkg::DFP_ST_OFF: begin
                if (pwm_on_cmd && valid_sync) begin
                    state_next = dfp_pkg::DFP_ST_BLANK;
                end
            end
            dfp_pkg::DFP_ST_BLANK: begin
                if (!pwm_on_cmd) begin
                    state_next = dfp_pkg::DFP_ST_OFF;
                end else if (blank_done) begin
                    state_next = dfp_pkg::DFP_ST_MONITOR;
                end
            end
            dfp_pkg::DFP_ST_MONITOR: begin
                if (sat_trip) begin
                    state_next = dfp_pkg::DFP_ST_DIS_A;
                end else if (!pwm_on_cmd) begin
                    state_next = dfp_pkg::DFP_ST_OFF;
                end
            end
            dfp_pkg::DFP_ST_DIS_A: begin
                if (fast_react) begin
                    state_next = dfp_pkg::DFP_ST_OFF;
                end
            end
            dfp_pkg::DFP_ST_DIS_B: begin
                state_next = dfp_pkg::DFP_ST_DIS_B;
            end
            default: begin
                state_next = dfp_pkg::DFP_ST_DIS_B;
            end
        endcase
        if (enable_loss && state_next != dfp_pkg::DFP_ST_DIS_B) begin
            state_next = dfp_pkg::DFP_ST_DIS_A;
        end
        if (internal_fault) begin
            state_next = dfp_pkg::DFP_ST_DIS_B;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || reinit) begin
            state_reg <= dfp_pkg::DFP_ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            safe_reg    <= 1'b0;
            regular_reg <= 1'b0;
        end else begin
            safe_reg    <= sat_trip && !internal_fault;
            regular_reg <= enable_loss && !sat_trip && !internal_fault
                           && state_reg != dfp_pkg::DFP_ST_DIS_A
                           && state_reg != dfp_pkg::DFP_ST_DIS_B;
        end
    end

    assign safe_turnoff    = safe_reg;
    assign regular_turnoff = regular_reg;

    assign gate_on = state_reg[1] | state_reg[2];
    // clamp during blanking, and while off if enabled
    assign sense_clamp = state_reg[1] | (clamp_en_reg & ~gate_on);

    assign fault_notify_class_a_n = ~state_reg[3];
    assign fault_notify_class_b_n = ~state_reg[4];

endmodule

// file: tb/dfp_sense_model.sv
// sense network model: pulled-up pin, internal clamp, desaturation source
// assumes gate_on and sense_clamp from the block, short_en from the bench
module dfp_sense_model (
    input  wire logic gate_on,
    input  wire logic sense_clamp,
    input  wire logic short_en,
    output logic      sense_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up charges the pin whenever it is released and the switch is off
    always_comb begin
        if (sense_clamp) begin
            sense_pin = 1'b0;
        end else if (gate_on) begin
            sense_pin = short_en;
        end else begin
            sense_pin = 1'b1;
        end
    end
endmodule

// file: tb/dfp_top_asserts.sv
// checker: trip, fault class and bus timing properties at the top ports
// assumes bound into dfp_top, one clock, synchronous active high reset
`include "dfp_regs.svh"
module dfp_top_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic pwm_on_cmd,
    input wire logic internal_fault,
    input wire logic class_c_event,
    input wire logic gate_on,
    input wire logic sense_clamp,
    input wire logic safe_turnoff,
    input wire logic regular_turnoff,
    input wire logic fault_notify_class_a_n,
    input wire logic fault_notify_class_b_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic wr_done;
    assign wr_done = avs_write && !avs_waitrequest;
    sequence s_dis_a;
        !fault_notify_class_a_n && !gate_on;
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_bus_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_trip_safe_off: assert property (
        safe_turnoff |-> s_dis_a ##1 !safe_turnoff)
        else $error("safe turn-off without class A disable");
    a_off_no_gate: assert property (
        !pwm_on_cmd |=> !gate_on)
        else $error("gate on without on command");
    a_blank_clamped: assert property (
        $rose(gate_on) |-> sense_clamp)
        else $error("sense pin released at turn-on");
    a_blank_no_trip: assert property (
        gate_on && sense_clamp |=> !safe_turnoff)
        else $error("trip during blanking");
    a_class_b_entry: assert property (
        internal_fault |=> !fault_notify_class_b_n && !gate_on)
        else $error("internal failure not class B");
    a_class_b_hold: assert property (
        !fault_notify_class_b_n && !wr_done |=> !fault_notify_class_b_n)
        else $error("class B left without register write");
    a_class_a_hold: assert property (
        !fault_notify_class_a_n && !wr_done && !internal_fault
        |=> !fault_notify_class_a_n)
        else $error("class A left without register write");
    a_class_c_quiet: assert property (
        class_c_event && fault_notify_class_a_n && fault_notify_class_b_n
        && !internal_fault |=> fault_notify_class_b_n
        && $stable(fault_notify_class_a_n))
        else $error("class C event changed fault state");
    a_enable_loss: assert property (
        regular_turnoff |-> s_dis_a ##1 !regular_turnoff)
        else $error("enable loss without class A disable");
endmodule
bind dfp_top dfp_top_asserts dfp_top_asserts_inst (
    .clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest, .pwm_on_cmd,
    .internal_fault, .class_c_event, .gate_on, .sense_clamp, .safe_turnoff,
    .regular_turnoff, .fault_notify_class_a_n, .fault_notify_class_b_n);

// file: tb/test_desaturation_fault_protection.sv
// self-checking bench: registers, desaturation trip, fault classes
// assumes dfp_top, dfp_sense_model and the bound checker are compiled
`include "dfp_regs.svh"
module test_desaturation_fault_protection;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk = 1'b0;
    logic                   sys_rst = 1'b1;
    logic [`DFP_ADDR_W-1:0] avs_address = '0;
    logic                   avs_read = 1'b0;
    logic                   avs_write = 1'b0;
    logic [31:0]            avs_writedata = '0;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    logic                   pwm_on_cmd = 1'b0;
    logic                   saturation_sense_pin;
    logic                   external_enable_input = 1'b1;
    logic                   internal_fault = 1'b0;
    logic                   class_c_event = 1'b0;
    logic                   short_en = 1'b0;
    logic                   gate_on;
    logic                   sense_clamp;
    logic [2:0]             thr_sel;
    logic                   safe_turnoff;
    logic                   regular_turnoff;
    logic                   notify_a_n;
    logic                   notify_b_n;
    logic                   irq;
    logic [31:0]            rd;
    int                     n;
    int                     mismatches = 0;
    int                     total_checks = 0;
    always #4 clk = ~clk;
    dfp_top #(.BLANK_W(8), .THR_W(3)) dfp_top_inst (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pwm_on_cmd(pwm_on_cmd), .saturation_sense_pin(saturation_sense_pin),
        .external_enable_input(external_enable_input),
        .internal_fault(internal_fault), .class_c_event(class_c_event),
        .gate_on(gate_on), .sense_clamp(sense_clamp),
        .saturation_threshold_select(thr_sel), .safe_turnoff(safe_turnoff),
        .regular_turnoff(regular_turnoff),
        .fault_notify_class_a_n(notify_a_n),
        .fault_notify_class_b_n(notify_b_n), .irq(irq));
    dfp_sense_model dfp_sense_model_inst (
        .gate_on(gate_on), .sense_clamp(sense_clamp), .short_en(short_en),
        .sense_pin(saturation_sense_pin));
    ////////////////////////////////////////////////////////////////////
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task bus(input logic wr_n_rd, input logic [`DFP_ADDR_W-1:0] a,
             input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr_n_rd;
        avs_read <= !wr_n_rd;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        q = avs_readdata;
        if (k >= 50) begin
            mismatches++;
            conclude();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [`DFP_ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rdc(input logic [`DFP_ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task wait_pulse(input logic sel, output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while ((sel ? regular_turnoff : safe_turnoff) !== 1'b1 && k < 60);
        if (k >= 60) begin
            mismatches++;
            conclude();
        end
        @(posedge clk);
    endtask
    task cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        cyc(8);
        sys_rst <= 1'b0;
        cyc(4);
        rdc(`DFP_BLANK_OFS, 32'h10);
        rdc(`DFP_CFG2_OFS, 32'h0);
        rdc(`DFP_MASK_OFS, 32'hf);
        rdc(5'h1c, 32'h0);
        wr(`DFP_CFG2_OFS, 32'h5);
        rdc(`DFP_CFG2_OFS, 32'h0);
        wr(`DFP_CTRL_OFS, 32'h2);
        wr(`DFP_CFG2_OFS, 32'h5);
        rdc(`DFP_CFG2_OFS, 32'h5);
        chk({29'h0, thr_sel}, 32'h5);
        wr(`DFP_BLANK_OFS, 32'h1);
        rdc(`DFP_BLANK_OFS, 32'h1);
        short_en <= 1'b1;
        pwm_on_cmd <= 1'b1;
        cyc(6);
        chk({29'h0, gate_on, sense_clamp, saturation_sense_pin}, 32'h6);
        wait_pulse(1'b0, n);
        chk({31'h0, n >= 10 && n <= 20}, 32'h1);
        chk({29'h0, notify_a_n, gate_on, irq}, 32'h1);
        rdc(`DFP_ERR_OFS, 32'h1);
        bus(1'b0, `DFP_STAT_OFS, 32'h0, rd);
        chk({26'h0, rd[12:8], rd[0]}, 32'h11);
        pwm_on_cmd <= 1'b0;
        cyc(4);
        chk({31'h0, notify_a_n}, 32'h0);
        wr(`DFP_ERR_OFS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`DFP_CTRL_OFS, 32'h6);
        chk({31'h0, notify_a_n}, 32'h1);
        cyc(20);
        rdc(`DFP_ERR_OFS, 32'h0);
        wr(`DFP_CTRL_OFS, 32'h1);
        chk({31'h0, sense_clamp}, 32'h1);
        wr(`DFP_CTRL_OFS, 32'h0);
        chk({31'h0, sense_clamp}, 32'h0);
        short_en <= 1'b0;
        pwm_on_cmd <= 1'b1;
        cyc(40);
        chk({29'h0, gate_on, sense_clamp, notify_a_n}, 32'h5);
        wr(`DFP_MASK_OFS, 32'h0);
        class_c_event <= 1'b1;
        cyc(1);
        class_c_event <= 1'b0;
        cyc(2);
        chk({29'h0, gate_on, notify_a_n, irq}, 32'h6);
        wr(`DFP_MASK_OFS, 32'hf);
        chk({31'h0, irq}, 32'h1);
        rdc(`DFP_ERR_OFS, 32'h8);
        wr(`DFP_ERR_OFS, 32'h8);
        external_enable_input <= 1'b0;
        wait_pulse(1'b1, n);
        chk({30'h0, gate_on, notify_a_n}, 32'h0);
        external_enable_input <= 1'b1;
        pwm_on_cmd <= 1'b0;
        rdc(`DFP_ERR_OFS, 32'h2);
        wr(`DFP_ERR_OFS, 32'h2);
        wr(`DFP_CTRL_OFS, 32'h4);
        chk({31'h0, notify_a_n}, 32'h1);
        internal_fault <= 1'b1;
        cyc(1);
        internal_fault <= 1'b0;
        cyc(2);
        chk({31'h0, notify_b_n}, 32'h0);
        wr(`DFP_CTRL_OFS, 32'h4);
        chk({31'h0, notify_b_n}, 32'h0);
        wr(`DFP_CTRL_OFS, 32'h8);
        chk({31'h0, notify_b_n}, 32'h1);
        rdc(`DFP_BLANK_OFS, 32'h10);
        rdc(`DFP_ERR_OFS, 32'h0);
        conclude();
    end
endmodule
